//--- rtl/reset_sequencer_and_watchdog.sv
// Device reset sequencer with watchdog and AHB-Lite register slave
//
// Chosen here: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ps
module reset_sequencer_and_watchdog import rsw_pkg::*; #(
    parameter int RC_DIV     = RC_DIV_CYCLES,
    parameter int POWERUP_DELAY_TIMER_TICKS = POWERUP_DELAY_TIMER_RC_TICKS
) (
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    input  wire logic        resetPinIn,
    output logic             resetPinOut,
    output logic             resetPinOe,
    input  wire logic        supplyLowIn,
    input  wire logic        oscInputPin,
    input  wire logic        wakeFromSleep,
    input  wire logic        oscFailDetect,
    output logic             deviceReset,
    output logic             oscSettled
);

    typedef struct packed {
        seq_state_type      state;
        logic [RCDIV_W-1:0] rcDiv;
        logic               rcTick;
        logic [POWERUP_DELAY_TIMER_W-1:0]  pwrtCnt;
        logic [OST_W-1:0]   ostCnt;
        logic [BOR_W-1:0]   borCnt;
        logic               borTrip;
        logic [FILT_W-1:0]  filtCnt;
        logic               mclrSync1;
        logic               mclrSync2;
        logic               mclrFilt;
        logic               oscSync1;
        logic               oscSync2;
        logic               oscPrev;
        logic               lowSync1;
        logic               lowSync2;
        logic               powerCause;
        logic [4:0]         wdtCtrl;
        logic [3:0]         option;
        logic [6:0]         cfg;
        logic               pinOut;
        logic               pinDir;
        logic               wdtFlag;
        logic               borFlag;
        logic               wdtRun;
        logic               clrPre;
        logic               clrPost;
        logic               aWrite;
        logic               aRead;
        logic [7:0]         aAddr;
        logic [31:0]        rdata;
        logic               ready;
        logic               resp;
        logic               pinOeQ;
        logic               pinOutQ;
        logic               devRst;
        logic               settled;
    } regs_type;

    regs_type    s;
    regs_type    next_s;
    logic        isXtal;
    logic        mclrLow;
    logic        holdReq;
    logic        oscEdge;
    logic        busWr;
    logic [31:0] rd;

    wdt_if wif ();

    watchdog_scaler u_scaler (
        .clk    (clk),
        .arst_n (arst_n),
        .wif    (wif.scaler)
    );

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        next_s = s;
        next_s.rcTick = 1'b0;
        next_s.clrPre = 1'b0;
        next_s.clrPost = 1'b0;
        next_s.resp = 1'b0;
        isXtal = (s.cfg[CFG_OSC_LSB+:3] == OSC_LP) || (s.cfg[CFG_OSC_LSB+:3] == OSC_XT)
                 || (s.cfg[CFG_OSC_LSB+:3] == OSC_HS);
        mclrLow = s.cfg[CFG_PIN_RESET_FUNCTION_ENABLE] && !s.mclrFilt;
        holdReq = mclrLow || s.borTrip;
        oscEdge = s.oscSync2 && !s.oscPrev;
        busWr = s.aWrite && hready;

        // Pin synchronisers
        next_s.mclrSync1 = resetPinIn;
        next_s.mclrSync2 = s.mclrSync1;
        next_s.oscSync1 = oscInputPin;
        next_s.oscSync2 = s.oscSync1;
        next_s.oscPrev = s.oscSync2;
        next_s.lowSync1 = supplyLowIn;
        next_s.lowSync2 = s.lowSync1;

        // Internal RC time base
        if (s.rcDiv == RCDIV_W'(RC_DIV - 1)) begin
            next_s.rcDiv = '0;
            next_s.rcTick = 1'b1;
        end else begin
            next_s.rcDiv = s.rcDiv + 1'b1;
        end

        // Master clear glitch filter
        if (s.mclrSync2 == s.mclrFilt) begin
            next_s.filtCnt = '0;
        end else if (s.filtCnt == FILT_LAST) begin
            next_s.mclrFilt = s.mclrSync2;
            next_s.filtCnt = '0;
        end else begin
            next_s.filtCnt = s.filtCnt + 1'b1;
        end

        // Register read
        rd = '0;
        case (s.aAddr)
            REG_WDT_CTRL: rd[4:0] = s.wdtCtrl;
            REG_OPTION: rd[3:0] = s.option;
            REG_CONFIG: rd[6:0] = s.cfg;
            REG_STATUS: begin
                rd[STAT_WDT] = s.wdtFlag;
                rd[STAT_BOR] = s.borFlag;
                rd[STAT_PIN] = s.mclrSync2;
                rd[STAT_ST_LSB+:5] = s.state;
            end
            REG_PIN: begin
                rd[PIN_OUT] = s.pinOut;
                rd[PIN_DIR] = s.pinDir;
            end
            default: rd = '0;
        endcase

        // Bus address and data phases
        if (s.aRead && !s.ready) begin
            next_s.rdata = rd;
            next_s.ready = 1'b1;
            next_s.aRead = 1'b0;
        end else if (hsel && htrans[HTRANS_ACT] && hready) begin
            next_s.aAddr = haddr[7:0];
            next_s.aWrite = hwrite;
            next_s.aRead = !hwrite;
            next_s.ready = hwrite;
        end else if (hready) begin
            next_s.aWrite = 1'b0;
            next_s.aRead = 1'b0;
        end
        if (busWr) begin
            case (s.aAddr)
                REG_WDT_CTRL: next_s.wdtCtrl = hwdata[4:0];
                REG_OPTION: next_s.option = hwdata[3:0];
                REG_CONFIG: next_s.cfg = hwdata[6:0];
                REG_COMMAND: begin
                    next_s.clrPre = hwdata[CMD_CLR_WDT];
                    next_s.clrPost = hwdata[CMD_CLR_WDT];
                end
                REG_STATUS: begin
                    next_s.wdtFlag = s.wdtFlag && !hwdata[STAT_WDT];
                    next_s.borFlag = s.borFlag && !hwdata[STAT_BOR];
                end
                REG_PIN: begin
                    next_s.pinOut = hwdata[PIN_OUT];
                    next_s.pinDir = hwdata[PIN_DIR];
                end
                default: next_s.rdata = s.rdata;
            endcase
        end
        if (oscFailDetect) begin
            next_s.clrPre = 1'b1;
        end

        // Brownout qualifier, independent of the power-up timer enable
        if (!s.cfg[CFG_BROWNOUT_ENABLE] || !s.lowSync2) begin
            next_s.borCnt = '0;
            next_s.borTrip = 1'b0;
        end else if (s.borCnt == BOR_LAST) begin
            next_s.borTrip = 1'b1;
            next_s.borFlag = 1'b1;
        end else begin
            next_s.borCnt = s.borCnt + 1'b1;
        end

        // Sequencer
        case (s.state)
            ST_HOLD: begin
                if (!holdReq) begin
                    if (s.powerCause && !s.cfg[CFG_POWERUP_TIMER_ENABLE_N_N]) begin
                        next_s.state = ST_POWERUP_DELAY_TIMER;
                        next_s.pwrtCnt = '0;
                    end else if (s.powerCause && isXtal) begin
                        next_s.state = ST_OST;
                        next_s.ostCnt = '0;
                    end else begin
                        next_s.state = ST_RUN;
                        next_s.powerCause = 1'b0;
                    end
                end
            end
            ST_POWERUP_DELAY_TIMER: begin
                if (s.rcTick) begin
                    if (s.pwrtCnt == POWERUP_DELAY_TIMER_W'(POWERUP_DELAY_TIMER_TICKS - 1)) begin
                        next_s.ostCnt = '0;
                        next_s.state = isXtal ? ST_OST : ST_RUN;
                        next_s.powerCause = isXtal;
                    end else begin
                        next_s.pwrtCnt = s.pwrtCnt + 1'b1;
                    end
                end
            end
            ST_OST, ST_WAKE: begin
                if (oscEdge) begin
                    if (s.ostCnt == OST_LAST) begin
                        next_s.state = ST_RUN;
                        next_s.powerCause = 1'b0;
                        next_s.clrPre = 1'b1;
                        next_s.clrPost = 1'b1;
                    end else begin
                        next_s.ostCnt = s.ostCnt + 1'b1;
                    end
                end
            end
            ST_RUN: begin
                if (wif.timeout) begin
                    next_s.state = ST_HOLD;
                    next_s.wdtFlag = 1'b1;
                end else if (wakeFromSleep && isXtal) begin
                    next_s.state = ST_WAKE;
                    next_s.ostCnt = '0;
                end
            end
            default: next_s.state = ST_HOLD;
        endcase
        if (s.borTrip) begin
            next_s.state = ST_HOLD;
            next_s.powerCause = 1'b1;
        end else if (mclrLow) begin
            next_s.state = ST_HOLD;
        end
        if (next_s.state == ST_HOLD) begin
            next_s.wdtCtrl = WDT_CTRL_RST;
        end

        // Watchdog enable, cleared whenever not running
        next_s.wdtRun = (next_s.cfg[CFG_WATCHDOG_FUSE_ENABLE] || next_s.wdtCtrl[WCTRL_SOFT_EN])
                        && (next_s.state == ST_RUN);

        // Registered outputs
        next_s.devRst = (next_s.state == ST_HOLD) || (next_s.state == ST_POWERUP_DELAY_TIMER)
                        || (next_s.state == ST_OST);
        next_s.settled = (next_s.state != ST_OST) && (next_s.state != ST_WAKE);
        next_s.pinOeQ = !next_s.cfg[CFG_PIN_RESET_FUNCTION_ENABLE] && next_s.pinDir;
        next_s.pinOutQ = next_s.pinOut;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s <= '0;
            s.state <= ST_HOLD;
            s.mclrSync1 <= 1'b1;
            s.mclrSync2 <= 1'b1;
            s.mclrFilt <= 1'b1;
            s.powerCause <= 1'b1;
            s.wdtCtrl <= WDT_CTRL_RST;
            s.option <= OPTION_RST;
            s.cfg <= CONFIG_RST;
            s.ready <= 1'b1;
            s.devRst <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign wif.tick      = s.rcTick;
    assign wif.run       = s.wdtRun;
    assign wif.clearPre  = s.clrPre;
    assign wif.clearPost = s.clrPost;
    assign wif.prescaler_assign       = s.option[OPT_PSA];
    assign wif.preSel    = s.wdtCtrl[WCTRL_PS_LSB+:4];
    assign wif.postSel   = s.option[OPT_PS_LSB+:3];
    assign hreadyout     = s.ready;
    assign hrdata        = s.rdata;
    assign hresp         = s.resp;
    assign resetPinOut   = s.pinOutQ;
    assign resetPinOe    = s.pinOeQ;
    assign deviceReset   = s.devRst;
    assign oscSettled    = s.settled;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    a_wdt_no_pin: assert property (wif.timeout && !s.aWrite |=> $stable(resetPinOe))
        else $error("watchdog reset changed the pin drive");
    a_pin_master_clear_pin_mode: assert property (s.cfg[CFG_PIN_RESET_FUNCTION_ENABLE] |-> !resetPinOe)
        else $error("pin driven while in master clear mode");
    a_powerup_delay_timer_holds: assert property (s.state == ST_POWERUP_DELAY_TIMER |-> deviceReset)
        else $error("reset released during power-up delay");
    a_powerup_delay_timer_skip: assert property (s.state == ST_HOLD && !holdReq && s.cfg[CFG_POWERUP_TIMER_ENABLE_N_N]
        |=> s.state != ST_POWERUP_DELAY_TIMER)
        else $error("power-up delay ran while disabled");
    a_ost_count: assert property (s.state == ST_OST && oscEdge && s.ostCnt == OST_LAST
        && !s.borTrip && !mclrLow |=> s.state == ST_RUN ##1 !deviceReset)
        else $error("settle count did not end at 1024 edges");
    a_ost_mode: assert property ($rose(s.state == ST_OST || s.state == ST_WAKE) |-> isXtal)
        else $error("settle count outside crystal modes");
    a_bor_off: assert property (!s.cfg[CFG_BROWNOUT_ENABLE] |=> !s.borTrip)
        else $error("brownout active while disabled");
    a_bor_persist: assert property ($rose(s.borTrip) |-> $past(s.borCnt) == BOR_LAST
        && $past(s.lowSync2, 2))
        else $error("brownout tripped before minimum duration");
    a_bor_hold: assert property (s.borTrip |=> s.state == ST_HOLD && deviceReset)
        else $error("brownout did not hold reset");
    a_wdt_held_ost: assert property (s.state == ST_OST |-> !s.wdtRun)
        else $error("watchdog running during settle count");
    a_fuse_run: assert property (s.cfg[CFG_WATCHDOG_FUSE_ENABLE] && s.state == ST_RUN
        && $past(s.state) == ST_RUN && $past(s.cfg[CFG_WATCHDOG_FUSE_ENABLE]) |-> s.wdtRun)
        else $error("fused watchdog not running");
    a_wdt_reset: assert property (wif.timeout |=> deviceReset && s.wdtFlag)
        else $error("watchdog timeout did not reset device");

    c_wdt_timeout: cover property (wif.timeout ##1 deviceReset);
    c_bor_trip: cover property ($rose(s.borTrip));
    c_wake_settle: cover property (s.state == ST_WAKE ##1 s.state == ST_RUN);
    c_bus_read: cover property (s.aRead && !s.ready ##1 s.ready);

endmodule

//--- rtl/rsw_pkg.sv
// Constants, register map and types for the reset sequencer and watchdog
package rsw_pkg;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_FREQ_HZ       = 20_000_000;
    localparam int RC_FREQ_HZ        = 31_250;
    localparam int RC_DIV_CYCLES     = CLK_FREQ_HZ / RC_FREQ_HZ;
    localparam int POWERUP_DELAY_TIMER_TIME_MS      = 72;
    localparam int POWERUP_DELAY_TIMER_RC_TICKS     = POWERUP_DELAY_TIMER_TIME_MS * RC_FREQ_HZ / 1000;
    localparam int BOR_MIN_TIME_US   = 100;
    localparam int BOR_MIN_CYCLES    = (BOR_MIN_TIME_US * (CLK_FREQ_HZ / 1000) + 999) / 1000;
    localparam int MASTER_CLEAR_PIN_FILT_TIME_NS = 500;
    localparam int MASTER_CLEAR_PIN_FILT_CYCLES  = (MASTER_CLEAR_PIN_FILT_TIME_NS * (CLK_FREQ_HZ / 1_000_000) + 999) / 1000;
    localparam int OST_OSC_CYCLES    = 1024;

    // ----------------------------------------------------------------
    // Counter widths
    // ----------------------------------------------------------------
    localparam int RCDIV_W = 10;
    localparam int POWERUP_DELAY_TIMER_W  = 12;
    localparam int BOR_W   = 11;
    localparam int OST_W   = 11;
    localparam int FILT_W  = 4;
    localparam int PRE_W   = 16;
    localparam int POST_W  = 7;

    localparam logic [BOR_W-1:0]  BOR_LAST  = BOR_W'(BOR_MIN_CYCLES - 1);
    localparam logic [OST_W-1:0]  OST_LAST  = OST_W'(OST_OSC_CYCLES - 1);
    localparam logic [FILT_W-1:0] FILT_LAST = FILT_W'(MASTER_CLEAR_PIN_FILT_CYCLES - 1);

    // ----------------------------------------------------------------
    // Watchdog scaler
    // ----------------------------------------------------------------
    localparam int         PRE_MIN_SHIFT = 5;
    localparam logic [3:0] PRE_SEL_MAX   = 4'hb;

    // ----------------------------------------------------------------
    // Register map, byte addresses
    // ----------------------------------------------------------------
    localparam logic [7:0] REG_WDT_CTRL = 8'h00;
    localparam logic [7:0] REG_OPTION   = 8'h04;
    localparam logic [7:0] REG_COMMAND  = 8'h08;
    localparam logic [7:0] REG_CONFIG   = 8'h0c;
    localparam logic [7:0] REG_STATUS   = 8'h10;
    localparam logic [7:0] REG_PIN      = 8'h14;

    // Field positions
    localparam int WCTRL_SOFT_EN = 0;
    localparam int WCTRL_PS_LSB  = 1;
    localparam int OPT_PSA       = 3;
    localparam int OPT_PS_LSB    = 0;
    localparam int CMD_CLR_WDT   = 0;
    localparam int CFG_PIN_RESET_FUNCTION_ENABLE     = 0;
    localparam int CFG_POWERUP_TIMER_ENABLE_N_N  = 1;
    localparam int CFG_BROWNOUT_ENABLE     = 2;
    localparam int CFG_WATCHDOG_FUSE_ENABLE     = 3;
    localparam int CFG_OSC_LSB   = 4;
    localparam int STAT_WDT      = 0;
    localparam int STAT_BOR      = 1;
    localparam int STAT_PIN      = 2;
    localparam int STAT_ST_LSB   = 4;
    localparam int PIN_OUT       = 0;
    localparam int PIN_DIR       = 1;
    localparam int HTRANS_ACT    = 1;

    // Reset values
    localparam logic [4:0] WDT_CTRL_RST = 5'h08;
    localparam logic [3:0] OPTION_RST   = 4'hf;
    localparam logic [6:0] CONFIG_RST   = 7'h15;

    // Oscillator modes
    localparam logic [2:0] OSC_LP = 3'h0;
    localparam logic [2:0] OSC_XT = 3'h1;
    localparam logic [2:0] OSC_HS = 3'h2;

    typedef enum logic [4:0] {
        ST_HOLD = 5'h01,
        ST_POWERUP_DELAY_TIMER = 5'h02,
        ST_OST  = 5'h04,
        ST_RUN  = 5'h08,
        ST_WAKE = 5'h10
    } seq_state_type;

endpackage

//--- rtl/wdt_if.sv
// Link between the sequencer and the watchdog scaler
`timescale 1ns/1ps
interface wdt_if;
    logic       tick;
    logic       run;
    logic       clearPre;
    logic       clearPost;
    logic       prescaler_assign;
    logic [3:0] preSel;
    logic [2:0] postSel;
    logic       timeout;

    modport ctrl   (output tick, run, clearPre, clearPost, prescaler_assign, preSel, postSel, input timeout);
    modport scaler (input tick, run, clearPre, clearPost, prescaler_assign, preSel, postSel, output timeout);
endinterface

//--- rtl/watchdog_scaler.sv
// Watchdog prescaler and postscaler counters
`timescale 1ns/1ps
module watchdog_scaler import rsw_pkg::*; (
    input  wire logic clk,
    input  wire logic arst_n,
    wdt_if.scaler     wif
);

    typedef struct packed {
        logic [PRE_W-1:0]  pre;
        logic [POST_W-1:0] post;
        logic              timeout;
    } scaler_type;

    scaler_type s;
    scaler_type next_s;
    logic [3:0]        selC;
    logic [PRE_W-1:0]  preLimit;
    logic [POST_W-1:0] postLimit;

    // ----------------------------------------------------------------
    // Counting
    // ----------------------------------------------------------------
    always_comb begin
        next_s = s;
        next_s.timeout = 1'b0;
        selC = (wif.preSel > PRE_SEL_MAX) ? PRE_SEL_MAX : wif.preSel;
        preLimit = PRE_W'((17'h1 << (PRE_MIN_SHIFT + int'(selC))) - 17'h1);
        postLimit = POST_W'((8'h1 << wif.postSel) - 8'h1);
        if (!wif.run) begin
            next_s.pre = '0;
            next_s.post = '0;
        end else if (wif.tick) begin
            if (s.pre == preLimit) begin
                next_s.pre = '0;
                if (wif.prescaler_assign) begin
                    if (s.post == postLimit) begin
                        next_s.post = '0;
                        next_s.timeout = 1'b1;
                    end else begin
                        next_s.post = s.post + 1'b1;
                    end
                end else begin
                    next_s.post = '0;
                    next_s.timeout = 1'b1;
                end
            end else begin
                next_s.pre = s.pre + 1'b1;
            end
        end
        if (wif.clearPre) begin
            next_s.pre = '0;
        end
        if (wif.clearPost) begin
            next_s.post = '0;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign wif.timeout = s.timeout;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    a_clear_both: assert property (@(posedge clk) disable iff (!arst_n)
        (wif.clearPre && wif.clearPost) |=> (s.pre == '0 && s.post == '0))
        else $error("scaler not cleared by clear command");
    a_timeout_restart: assert property (@(posedge clk) disable iff (!arst_n)
        s.timeout |-> (s.pre == '0 && s.post == '0 && $past(wif.run)))
        else $error("scaler did not restart after timeout");

endmodule

//--- tb/pin_supply_model.sv
// Far side: master clear pin, supply monitor and crystal
`timescale 1ns/1ps
module pin_supply_model (
    input  wire logic clk,
    output logic      pinLevel,
    output logic      supplyLow,
    output logic      oscClk
);
    initial begin
        pinLevel = 1'b1;
        supplyLow = 1'b0;
        oscClk = 1'b0;
    end
    // Crystal at a 206 ns period, just under a quarter of clk, unrelated in phase
    always begin
        #103 oscClk = ~oscClk;
    end
    // Pull pin low (sel 0) or dip supply (sel 1) for n cycles
    task automatic drive(input bit sel, input int n);
        @(posedge clk);
        if (sel) supplyLow <= 1'b1;
        else pinLevel <= 1'b0;
        repeat (n) @(posedge clk);
        supplyLow <= 1'b0;
        pinLevel <= 1'b1;
    endtask
endmodule

//--- tb/reset_sequencer_and_watchdog_tb.sv
// Self-checking bench for the reset sequencer and watchdog
`timescale 1ns/1ps
module reset_sequencer_and_watchdog_tb;
    import rsw_pkg::*;
    logic        clk = 0, arst_n = 0, hsel = 0, hwrite = 0, wake = 0, oscFail = 0, resetPinIn;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, r;
    logic [1:0]  htrans = 0;
    logic        hreadyout, hresp, resetPinOut, resetPinOe, deviceReset, oscSettled, pinLevel, supplyLow, oscClk;
    logic [31:0] expQ[$];
    int          failures = 0, total_checks = 0, rstSeen = 0;
    bit          rdPhase = 0;
    always #25 clk = ~clk;
    assign resetPinIn = resetPinOe ? resetPinOut : pinLevel;
    pin_supply_model far_u (.clk(clk), .pinLevel(pinLevel), .supplyLow(supplyLow), .oscClk(oscClk));
    reset_sequencer_and_watchdog #(.RC_DIV(4), .POWERUP_DELAY_TIMER_TICKS(3)) dut_u (.clk(clk), .arst_n(arst_n),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .resetPinIn(resetPinIn),
        .resetPinOut(resetPinOut), .resetPinOe(resetPinOe), .supplyLowIn(supplyLow), .oscInputPin(oscClk),
        .wakeFromSleep(wake), .oscFailDetect(oscFail), .deviceReset(deviceReset), .oscSettled(oscSettled));
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        expQ.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask
    // Read data checked against the oldest note
    always @(posedge clk) begin
        if (deviceReset === 1'b1) rstSeen++;
        if (rdPhase && hreadyout === 1'b1) chk("hrdata", expQ.pop_front(), hrdata);
        if (rdPhase && hreadyout === 1'b1) chk("hresp", 32'h0, {31'h0, hresp});
        if (hreadyout === 1'b1) rdPhase <= hsel && htrans[1] && !hwrite;
    end
    task automatic waitRst(input logic lvl, input int n);
        for (int i = 0; i < n && deviceReset !== lvl; i++) @(posedge clk);
        chk("deviceReset", {31'h0, lvl}, {31'h0, deviceReset});
    endtask
    task automatic noRst(input int n);
        int s;
        s = rstSeen;
        repeat (n) @(posedge clk);
        chk("reset count", s, rstSeen);
    endtask
    task automatic expRst(input bit sel, input int n, input bit e);
        int s;
        s = rstSeen;
        far_u.drive(sel, n);
        waitRst(1'b0, 6000);
        chk("reset seen", {31'h0, e}, {31'h0, rstSeen != s});
    endtask
    task automatic final_report;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial begin
        #3ms;
        failures++;
        final_report();
    end
    initial begin
        void'($urandom(32'h83d82999));
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        rd(REG_WDT_CTRL, 32'h08);
        rd(REG_CONFIG, 32'h15);
        rd(8'h18, 32'h0);
        for (int i = 0; i < 200 && oscSettled !== 1'b0; i++) @(posedge clk);
        chk("oscSettled", 32'h0, {31'h0, oscSettled});
        waitRst(1'b0, 8000);
        chk("oscSettled", 32'h1, {31'h0, oscSettled});
        $display("power-up test done");
        r = $urandom & 32'h3;
        bus(1'b1, REG_PIN, r);
        rd(REG_PIN, r);
        chk("resetPinOe", 32'h0, {31'h0, resetPinOe});
        bus(1'b1, REG_CONFIG, 32'h14);
        bus(1'b1, REG_PIN, 32'h2);
        @(posedge clk);
        chk("resetPinOe", 32'h1, {31'h0, resetPinOe});
        noRst(40);
        bus(1'b1, REG_PIN, 32'h0);
        repeat (20) @(posedge clk);
        bus(1'b1, REG_CONFIG, 32'h15);
        expRst(1'b0, 5, 1'b0);
        expRst(1'b0, 40, 1'b1);
        expRst(1'b1, 100, 1'b0);
        expRst(1'b1, 2100, 1'b1);
        rd(REG_STATUS, 32'h86);
        bus(1'b1, REG_STATUS, 32'h2);
        bus(1'b1, REG_CONFIG, 32'h11);
        expRst(1'b1, 2100, 1'b0);
        bus(1'b1, REG_CONFIG, 32'h15);
        $display("pin and supply test done");
        bus(1'b1, REG_OPTION, 32'h0);
        bus(1'b1, REG_WDT_CTRL, 32'h1);
        noRst(110);
        waitRst(1'b1, 40);
        waitRst(1'b0, 20);
        chk("resetPinOe", 32'h0, {31'h0, resetPinOe});
        rd(REG_STATUS, 32'h85);
        rd(REG_WDT_CTRL, 32'h08);
        noRst(600);
        bus(1'b1, REG_STATUS, 32'h1);
        bus(1'b1, REG_OPTION, 32'h9);
        bus(1'b1, REG_WDT_CTRL, 32'h1);
        noRst(240);
        waitRst(1'b1, 40);
        bus(1'b1, REG_OPTION, 32'h0);
        bus(1'b1, REG_WDT_CTRL, 32'h1);
        repeat (3) begin
            noRst(100);
            oscFail <= 1'b1;
            @(posedge clk);
            oscFail <= 1'b0;
        end
        waitRst(1'b1, 160);
        $display("soft watchdog test done");
        bus(1'b1, REG_OPTION, 32'h0);
        bus(1'b1, REG_CONFIG, 32'h1d);
        repeat (3) begin
            noRst(1500);
            bus(1'b1, REG_COMMAND, 32'h1);
        end
        waitRst(1'b1, 2200);
        waitRst(1'b0, 20);
        bus(1'b1, REG_CONFIG, 32'h15);
        $display("fuse watchdog test done");
        wake <= 1'b1;
        @(posedge clk);
        wake <= 1'b0;
        @(posedge clk);
        chk("oscSettled", 32'h0, {31'h0, oscSettled});
        noRst(4500);
        chk("oscSettled", 32'h1, {31'h0, oscSettled});
        $display("wake test done");
        final_report();
    end
endmodule
